// [hw/dcrl_top.sv]
// register-side logic of an 18-bit voltage dac: mode, clear value and
// software action registers behind a 24-bit serial port plus the
// hardware load, preset and reset pins.
// assumes all pins are asynchronous to core_clk and sclk is far slower.
`timescale 1ns/1ps
module dcrl_top
	import dcrl_pkg::*;
(
	input  wire logic                 core_clk,
	input  wire logic                 rst_n,
	input  wire logic                 sclk,
	input  wire logic                 sync_n,
	input  wire logic                 sdin,
	input  wire logic                 output_load_n,
	input  wire logic                 preset_request_n,
	input  wire logic                 hw_reset_n,
	output logic                      sdo_out,
	output logic                      sdo_oe_n,
	output logic      [CODE_BITS-1:0] dac_code,
	output logic                      core_hiz_select,
	output logic                      output_ground_clamp,
	output logic                      code_format_select,
	output logic      [3:0]           lin_trim,
	output logic                      amp_bypass,
	output logic                      in_reset
);

	logic [PIN_COUNT-1:0]  pin_raw;
	logic [PIN_COUNT-1:0]  pin_s;
	logic [FRAME_BITS-1:0] frame_word;
	logic                  frame_valid;
	logic [FRAME_BITS-1:0] tx_word;
	logic                  tx_load;
	logic                  sdo_bit;

	logic [DATA_BITS-1:0]  mode_control_register;
	logic [CODE_BITS-1:0]  clear_value_register;
	logic [CODE_BITS-1:0]  input_code;
	logic [CODE_BITS-1:0]  dac_reg;
	logic                  soft_reset;
	logic                  sw_load;
	logic                  sw_clear;
	logic                  wipe;

	logic                  f_read;
	logic [2:0]            f_addr;
	logic [DATA_BITS-1:0]  f_data;
	logic                  f_ok;
	logic                  act_frame;
	logic                  next_load;
	logic                  next_clear;

	assign pin_raw[PIN_SCLK]     = sclk;
	assign pin_raw[PIN_SYNC_N]   = sync_n;
	assign pin_raw[PIN_SDIN]     = sdin;
	assign pin_raw[PIN_LOAD_N]   = output_load_n;
	assign pin_raw[PIN_PRESET_N] = preset_request_n;
	assign pin_raw[PIN_HWRST_N]  = hw_reset_n;

	// two flops per pin; only the second stage is read anywhere
	genvar gi;
	generate
		for (gi = 0; gi < PIN_COUNT; gi = gi + 1) begin : g_sync
			logic meta;
			always_ff @(posedge core_clk) begin
				if (!rst_n) begin
					meta      <= PIN_IDLE[gi];
					pin_s[gi] <= PIN_IDLE[gi];
				end else begin
					meta      <= pin_raw[gi];
					pin_s[gi] <= meta;
				end
			end
		end
	endgenerate

	dcrl_frame_shift u_shift (
		.core_clk    (core_clk),
		.rst_n       (rst_n),
		.sclk_s      (pin_s[PIN_SCLK]),
		.sync_n_s    (pin_s[PIN_SYNC_N]),
		.sdin_s      (pin_s[PIN_SDIN]),
		.tx_word     (tx_word),
		.tx_load     (tx_load),
		.frame_word  (frame_word),
		.frame_valid (frame_valid),
		.sdo_bit     (sdo_bit)
	);

	// converts a stored code to the offset binary code the core needs
	function automatic logic [CODE_BITS-1:0] to_core_code(
		input logic [CODE_BITS-1:0] code,
		input logic                 offset_bin
	);
		to_core_code = offset_bin ? code : {~code[CODE_BITS-1], code[CODE_BITS-2:0]};
	endfunction

	// pin low, soft reset pulse or core reset all mean power-on state
	assign wipe = !rst_n || !pin_s[PIN_HWRST_N] || soft_reset;

	// frame fields
	assign f_read = frame_word[RW_POS];
	assign f_addr = frame_word[ADDR_HI:ADDR_LO];
	assign f_data = frame_word[DATA_BITS-1:0];
	assign f_ok   = frame_valid && pin_s[PIN_HWRST_N];
	assign act_frame = f_ok && !f_read && f_addr == ADDR_ACTION;

	// soft reset is a one-cycle pulse one cycle after the frame pulse; the wipe it causes does not clear it
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			soft_reset <= 1'b0;
		end else begin
			soft_reset <= act_frame && f_data[ACT_RESET_POS];
		end
	end

	// software load and clear are ignored while the opposite pin is low
	assign next_load  = act_frame && f_data[ACT_LOAD_POS] && pin_s[PIN_PRESET_N];
	assign next_clear = act_frame && f_data[ACT_CLEAR_POS] && pin_s[PIN_LOAD_N];

	always_ff @(posedge core_clk) begin
		if (wipe) begin
			sw_load  <= 1'b0;
			sw_clear <= 1'b0;
		end else begin
			sw_load  <= next_load;
			sw_clear <= next_clear;
		end
	end

	// mode control register; reserved bits stay zero
	always_ff @(posedge core_clk) begin
		if (wipe) begin
			mode_control_register <= MODE_RESET;
		end else if (f_ok && !f_read && f_addr == ADDR_MODE) begin
			mode_control_register <= f_data & MODE_WMASK;
		end
	end

	// clear value register
	always_ff @(posedge core_clk) begin
		if (wipe) begin
			clear_value_register <= CLEAR_RESET;
		end else if (f_ok && !f_read && f_addr == ADDR_CLEAR) begin
			// 18-bit codes sit left-aligned in the data field, two low bits ignored
			clear_value_register <= f_data[DATA_BITS-1:DATA_BITS-CODE_BITS];
		end
	end

	// holding register written by the serial port, moved on a load
	always_ff @(posedge core_clk) begin
		if (wipe) begin
			input_code <= DAC_RESET;
		end else if (f_ok && !f_read && f_addr == ADDR_DAC) begin
			input_code <= f_data[DATA_BITS-1:DATA_BITS-CODE_BITS];
		end
	end

	// clear beats load: preset pin low or software clear forces clear value
	always_ff @(posedge core_clk) begin
		if (wipe) begin
			dac_reg <= DAC_RESET;
		end else if (!pin_s[PIN_PRESET_N] || sw_clear) begin
			dac_reg <= clear_value_register;
		end else if (!pin_s[PIN_LOAD_N] || sw_load) begin
			dac_reg <= input_code;
		end
	end

	// clear value and dac data share one decode through the format bit
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			dac_code <= to_core_code(DAC_RESET, MODE_RESET[FORMAT_POS]);
		end else begin
			dac_code <= to_core_code(dac_reg, mode_control_register[FORMAT_POS]);
		end
	end

	// output state outputs, one cycle behind the register
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			core_hiz_select     <= 1'b1;
			output_ground_clamp <= 1'b1;
			code_format_select  <= 1'b0;
			lin_trim            <= 4'h0;
			amp_bypass          <= 1'b1;
		end else begin
			// clamp also tristates the core, whatever the tristate bit says
			core_hiz_select     <= mode_control_register[HIZ_POS] ||
			                       mode_control_register[CLAMP_POS];
			output_ground_clamp <= mode_control_register[CLAMP_POS];
			code_format_select  <= mode_control_register[FORMAT_POS];
			lin_trim            <= mode_control_register[TRIM_HI:TRIM_LO];
			amp_bypass          <= mode_control_register[AMP_BYPASS_POS];
		end
	end

	// readback word for the next frame; action register reads zero
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			tx_word <= '0;
			tx_load <= 1'b0;
		end else begin
			tx_load <= f_ok && f_read;
			if (f_ok && f_read) begin
				if (f_addr == ADDR_MODE) begin
					tx_word <= {1'b1, f_addr, mode_control_register};
				end else if (f_addr == ADDR_CLEAR) begin
					tx_word <= {1'b1, f_addr, clear_value_register, 2'b00};
				end else if (f_addr == ADDR_DAC) begin
					tx_word <= {1'b1, f_addr, dac_reg, 2'b00};
				end else begin
					tx_word <= {1'b1, f_addr, 20'h00000};
				end
			end
		end
	end

	// sdo pin: driven unless disabled; enable is active low
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			sdo_out  <= 1'b0;
			sdo_oe_n <= MODE_RESET[SDO_DIS_POS];
			in_reset <= 1'b1;
		end else begin
			sdo_out  <= sdo_bit;
			sdo_oe_n <= mode_control_register[SDO_DIS_POS];
			in_reset <= !pin_s[PIN_HWRST_N];
		end
	end

endmodule

// [hw/dcrl_pkg.sv]
// constants for the dac control register logic: frame layout, addresses,
// control field positions, reset values and pin synchroniser indices.
// assumes a 24-bit msb-first serial frame sampled by a 100 MHz core clock.
package dcrl_pkg;

	localparam int          FRAME_BITS    = 24;
	localparam int          CODE_BITS     = 18;
	localparam int          DATA_BITS     = 20;
	localparam int          RW_POS        = 23;
	localparam int          ADDR_HI       = 22;
	localparam int          ADDR_LO       = 20;
	localparam int          CNT_BITS      = 5;
	localparam logic [4:0]  LAST_BIT      = 5'h17;

	localparam logic [2:0]  ADDR_DAC      = 3'h1;
	localparam logic [2:0]  ADDR_MODE     = 3'h2;
	localparam logic [2:0]  ADDR_CLEAR    = 3'h3;
	localparam logic [2:0]  ADDR_ACTION   = 3'h4;

	// mode_control_register fields
	localparam int          AMP_BYPASS_POS = 1;
	localparam int          CLAMP_POS      = 2;
	localparam int          HIZ_POS        = 3;
	localparam int          FORMAT_POS     = 4;
	localparam int          SDO_DIS_POS    = 5;
	localparam int          TRIM_LO        = 6;
	localparam int          TRIM_HI        = 9;
	localparam logic [19:0] MODE_RESET     = 20'h0000e;
	localparam logic [19:0] MODE_WMASK     = 20'h003fe;

	// software_action_register fields
	localparam int          ACT_LOAD_POS   = 0;
	localparam int          ACT_CLEAR_POS  = 1;
	localparam int          ACT_RESET_POS  = 2;

	localparam logic [17:0] CLEAR_RESET    = 18'h00000;
	localparam logic [17:0] DAC_RESET      = 18'h00000;
	localparam logic [3:0]  TRIM_20V       = 4'hc;

	// pin synchroniser lanes
	localparam int          PIN_SCLK      = 0;
	localparam int          PIN_SYNC_N    = 1;
	localparam int          PIN_SDIN      = 2;
	localparam int          PIN_LOAD_N    = 3;
	localparam int          PIN_PRESET_N  = 4;
	localparam int          PIN_HWRST_N   = 5;
	localparam int          PIN_COUNT     = 6;
	localparam logic [5:0]  PIN_IDLE      = 6'h3b;

	typedef enum logic [1:0] {
		DCRL_IDLE  = 2'b00,
		DCRL_SHIFT = 2'b01,
		DCRL_DONE  = 2'b10
	} dcrl_frame_t;

endpackage

// [hw/dcrl_frame_shift.sv]
// serial frame shifter: 24-bit msb-first receive and readback transmit.
// inputs are already synchronised to core_clk; edges of sclk found here.
`timescale 1ns/1ps
module dcrl_frame_shift
	import dcrl_pkg::*;
(
	input  wire logic                  core_clk,
	input  wire logic                  rst_n,
	input  wire logic                  sclk_s,
	input  wire logic                  sync_n_s,
	input  wire logic                  sdin_s,
	input  wire logic [FRAME_BITS-1:0] tx_word,
	input  wire logic                  tx_load,
	output logic      [FRAME_BITS-1:0] frame_word,
	output logic                       frame_valid,
	output logic                       sdo_bit
);

	logic                  sclk_d;
	logic                  sync_d;
	logic [FRAME_BITS-1:0] rx_sh;
	logic [FRAME_BITS-1:0] tx_sh;
	logic [CNT_BITS-1:0]   cnt;
	dcrl_frame_t           st;
	logic                  sclk_fall;
	logic                  sclk_rise;
	logic                  sync_fall;

	assign sclk_fall = sclk_d & ~sclk_s;
	assign sclk_rise = ~sclk_d & sclk_s;
	assign sync_fall = sync_d & ~sync_n_s;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			sclk_d <= 1'b1;
			sync_d <= 1'b1;
		end else begin
			sclk_d <= sclk_s;
			sync_d <= sync_n_s;
		end
	end

	// bits beyond the 24th are dropped; a short frame is discarded
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			st          <= DCRL_IDLE;
			cnt         <= '0;
			rx_sh       <= '0;
			frame_word  <= '0;
			frame_valid <= 1'b0;
		end else begin
			frame_valid <= 1'b0;
			case (st)
				DCRL_IDLE: begin
					cnt <= '0;
					if (!sync_n_s)
						st <= DCRL_SHIFT;
				end
				DCRL_SHIFT: begin
					if (sync_n_s) begin
						st <= DCRL_IDLE;
					end else if (sclk_fall) begin
						rx_sh <= {rx_sh[FRAME_BITS-2:0], sdin_s};
						cnt   <= cnt + 5'h01;
						if (cnt == LAST_BIT) begin
							frame_word  <= {rx_sh[FRAME_BITS-2:0], sdin_s};
							frame_valid <= 1'b1;
							st          <= DCRL_DONE;
						end
					end
				end
				DCRL_DONE: begin
					if (sync_n_s)
						st <= DCRL_IDLE;
				end
				default: st <= DCRL_IDLE;
			endcase
		end
	end

	// readback leaves msb first, first bit at frame start, rest on rising sclk
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			tx_sh   <= '0;
			sdo_bit <= 1'b0;
		end else if (tx_load) begin
			tx_sh <= tx_word;
		// only inside a frame: the rise after a read frame's last bit must not shift
		end else if (sync_fall || (sclk_rise && st == DCRL_SHIFT && cnt != '0)) begin
			sdo_bit <= tx_sh[FRAME_BITS-1];
			tx_sh   <= {tx_sh[FRAME_BITS-2:0], 1'b0};
		end
	end

endmodule

// [sim/dcrl_top_checker.sv]
// checker for dcrl_top: reset values, clamp priority, pin reset, quiet periods.
// assumes the serial host raises sync_n well after each frame's last bit.
`timescale 1ns/1ps
module dcrl_top_checker
	import dcrl_pkg::*;
(
	input wire logic			core_clk,
	input wire logic			rst_n,
	input wire logic			sync_n,
	input wire logic			output_load_n,
	input wire logic			preset_request_n,
	input wire logic			hw_reset_n,
	input wire logic			sdo_oe_n,
	input wire logic [CODE_BITS-1:0]	dac_code,
	input wire logic			core_hiz_select,
	input wire logic			output_ground_clamp,
	input wire logic			code_format_select,
	input wire logic [3:0]			lin_trim,
	input wire logic			in_reset
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	a_clamp_forces_hiz:
	assert property (output_ground_clamp |-> core_hiz_select) else $error("clamp without tristate");
	a_reset_defaults:
	assert property (!$past(rst_n) |-> core_hiz_select && output_ground_clamp && !sdo_oe_n
		&& !code_format_select && lin_trim == 4'h0 && dac_code == 18'h20000)
		else $error("bad value after reset");
	a_hw_reset_seen:
	assert property ($fell(hw_reset_n) |-> ##[1:4] in_reset) else $error("reset pin not seen");
	a_in_reset_clear:
	assert property (hw_reset_n [*6] |-> !in_reset) else $error("reset flag stuck");
	a_hw_reset_wipe:
	assert property (in_reset [*2] |-> output_ground_clamp && lin_trim == 4'h0
		&& !code_format_select && dac_code == 18'h20000) else $error("reset pin did not wipe");
	a_idle_mode_stable:
	assert property (sync_n && $past(sync_n, 8) && hw_reset_n && $past(hw_reset_n, 4)
		|-> $stable(code_format_select) && $stable(lin_trim) && $stable(sdo_oe_n))
		else $error("mode changed without frame");
	a_preset_holds_code:
	assert property ((!preset_request_n && sync_n) [*8] |-> $stable(dac_code))
		else $error("code moved under clear pin");
	a_load_holds_code:
	assert property ((!output_load_n && preset_request_n && sync_n) [*8] |-> $stable(dac_code))
		else $error("code moved under load pin");
endmodule
bind dcrl_top dcrl_top_checker u_dcrl_top_checker (.core_clk, .rst_n, .sync_n, .output_load_n,
	.preset_request_n, .hw_reset_n, .sdo_oe_n, .dac_code, .core_hiz_select,
	.output_ground_clamp, .code_format_select, .lin_trim, .in_reset);

// [sim/dcrl_host.sv]
// host serial master model: 24-bit msb-first frames, write or read, sdo sampled into rx, sclk 160 ns.
// assumes the bench calls send just after a core clock edge.
`timescale 1ns/1ps
module dcrl_host (
	output logic	sclk,
	output logic	sync_n,
	output logic	sdin,
	input  logic	sdo
);
	logic [23:0]	rx;
	initial begin
		sclk = 1'b1;
		sync_n = 1'b1;
		sdin = 1'b0;
		rx = 24'h000000;
	end
	// sclk stands still high between frames; n below 24 truncates the frame
	task automatic send(input logic [23:0] w, input int n);
		sync_n = 1'b0;
		for (int i = 23; i > 23 - n; i--) begin
			sdin = w[i];
			#80 sclk = 1'b0;
			rx = {rx[22:0], sdo};
			#80 sclk = 1'b1;
		end
		#80 sync_n = 1'b1;
		sdin = ~sdin;
		#400;
	endtask
endmodule

// [sim/dcrl_top_tb_top.sv]
// bench for dcrl_top: serial writes via the host model, pin pulses, resets.
// assumes a 100 MHz core clock and the checker bound into dcrl_top.
`timescale 1ns/1ps
module dcrl_top_tb_top
	import dcrl_pkg::*;
;
	logic			core_clk, rst_n, output_load_n, preset_request_n, hw_reset_n;
	wire			sclk, sync_n, sdin;
	logic			sdo_out, sdo_oe_n, core_hiz_select, output_ground_clamp;
	logic			code_format_select, amp_bypass, in_reset;
	logic [CODE_BITS-1:0]	dac_code, cv, hv;
	logic [3:0]		lin_trim;
	logic [19:0]		m;
	logic			hit;
	// a disabled sdo shows the inverse, so a late enable cannot pass unseen
	wire			sdo_line = sdo_oe_n ? ~sdo_out : sdo_out;
	int			num_errors = 0, check_count = 0, seed = 64026;
	wire [8:0]		seen_mode = {core_hiz_select, output_ground_clamp,
				code_format_select, sdo_oe_n, lin_trim, amp_bypass};
	dcrl_top u_dcrl_top (.core_clk, .rst_n, .sclk, .sync_n, .sdin, .output_load_n,
		.preset_request_n, .hw_reset_n, .sdo_out, .sdo_oe_n, .dac_code, .core_hiz_select,
		.output_ground_clamp, .code_format_select, .lin_trim, .amp_bypass, .in_reset);
	dcrl_host u_dcrl_host (.sclk, .sync_n, .sdin, .sdo(sdo_line));
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	task automatic check(input string what, input logic [31:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	function automatic logic [17:0] enc(input logic [17:0] v, input logic f);
		return f ? v : {~v[17], v[16:0]};
	endfunction
	function automatic logic [8:0] mexp(input logic [19:0] r);
		return {r[HIZ_POS] | r[CLAMP_POS], r[CLAMP_POS], r[FORMAT_POS], r[SDO_DIS_POS],
			r[TRIM_HI:TRIM_LO], r[AMP_BYPASS_POS]};
	endfunction
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	// data sits in 19..2; the two don't-care bits are set to prove they are ignored
	task automatic wr(input logic [2:0] a, input logic [17:0] d);
		u_dcrl_host.send({1'b0, a, d, 2'h3}, 24);
	endtask
	task automatic mode_ok(input logic [19:0] r, input logic [17:0] v, input string t);
		check({t, " mode"}, seen_mode, mexp(r));
		check({t, " code"}, dac_code, enc(v, r[FORMAT_POS]));
		$display("test %s done", t);
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		#900000;
		num_errors++;
		summarize();
	end
	initial begin
		rst_n = 1'b0;
		output_load_n = 1'b1;
		preset_request_n = 1'b1;
		hw_reset_n = 1'b1;
		tick(8);
		rst_n = 1'b1;
		tick(6);
		mode_ok(MODE_RESET, 18'h0, "reset");
		u_dcrl_host.send({1'b0, ADDR_MODE, 20'h00300}, 24);
		mode_ok(20'h00300, 18'h0, "trim");
		for (int i = 0; i < 4; i++) begin
			m = 20'($random(seed)) & MODE_WMASK;
			m[FORMAT_POS] = i[0];
			cv = 18'($random(seed));
			hv = 18'($random(seed));
			u_dcrl_host.send({1'b0, ADDR_MODE, m}, 24);
			wr(ADDR_CLEAR, cv);
			u_dcrl_host.send({1'b0, ADDR_ACTION, 20'h00001}, 24);
			u_dcrl_host.send({1'b0, ADDR_ACTION, 20'h2}, 24);
			mode_ok(m, cv, "clear");
			wr(ADDR_DAC, hv);
			u_dcrl_host.send({1'b0, ADDR_ACTION, 20'h1}, 24);
			mode_ok(m, hv, "load");
		end
		preset_request_n = 1'b0;
		tick(10);
		wr(ADDR_DAC, ~hv);
		u_dcrl_host.send({1'b0, ADDR_ACTION, 20'h1}, 24);
		preset_request_n = 1'b1;
		tick(8);
		mode_ok(m, cv, "load_blocked");
		output_load_n = 1'b0;
		tick(8);
		hit = 1'b0;
		// a clear that slips through shows the clear value for one cycle
		fork
			u_dcrl_host.send({1'b0, ADDR_ACTION, 20'h2}, 24);
			repeat (430) begin
				@(posedge core_clk);
				#1;
				if (dac_code === enc(cv, m[FORMAT_POS]))
					hit = 1'b1;
			end
		join
		check("clear_blocked glitch", hit, 1'b0);
		mode_ok(m, ~hv, "clear_blocked");
		output_load_n = 1'b1;
		u_dcrl_host.send({1'b0, ADDR_MODE, 20'h0003e}, 23);
		mode_ok(m, ~hv, "short");
		u_dcrl_host.send({1'b0, ADDR_ACTION, 20'h4}, 24);
		mode_ok(MODE_RESET, 18'h0, "sw_reset");
		wr(ADDR_CLEAR, cv);
		hw_reset_n = 1'b0;
		wr(ADDR_MODE, 18'h000cc);
		check("in_reset", in_reset, 1'b1);
		hw_reset_n = 1'b1;
		tick(8);
		u_dcrl_host.send({1'b0, ADDR_ACTION, 20'h2}, 24);
		mode_ok(MODE_RESET, 18'h0, "hw_reset");
		wr(ADDR_CLEAR, cv);
		u_dcrl_host.send({1'b1, ADDR_CLEAR, 20'h00000}, 24);
		u_dcrl_host.send({1'b1, ADDR_CLEAR, 20'h00000}, 24);
		check("readback", u_dcrl_host.rx, {1'b1, ADDR_CLEAR, cv, 2'b00});
		$display("test readback done");
		summarize();
	end
endmodule
